/* File: src/lrb_pkg.sv */
`default_nettype none
package lrb_pkg;

  localparam logic [7:0] OFF_BRIGHT      = 8'h00;
  localparam logic [7:0] OFF_CURRENT     = 8'h02;
  localparam logic [7:0] OFF_CFG1        = 8'h04;
  localparam logic [7:0] OFF_CFG2        = 8'h06;
  localparam logic [7:0] OFF_IEN_SUP     = 8'h08;
  localparam logic [7:0] OFF_IEN_BST     = 8'h0A;
  localparam logic [7:0] OFF_IEN_LED     = 8'h0C;
  localparam logic [7:0] OFF_FLT_SUP     = 8'h0E;
  localparam logic [7:0] OFF_FLT_BST     = 8'h10;
  localparam logic [7:0] OFF_FLT_LED     = 8'h12;
  localparam logic [7:0] OFF_DIAG_FSM    = 8'h14;
  localparam logic [7:0] OFF_DIAG_PWMIN  = 8'h16;
  localparam logic [7:0] OFF_DIAG_PWMOUT = 8'h18;
  localparam logic [7:0] OFF_DIAG_DAC    = 8'h1A;
  localparam logic [7:0] OFF_DIAG_BOOST  = 8'h1C;
  localparam logic [7:0] OFF_DIAG_PIN    = 8'h1E;
  localparam logic [7:0] OFF_LAST        = 8'h1E;

  localparam logic [15:0] RST_BRIGHT  = 16'h0000;
  localparam logic [15:0] RST_CURRENT = 16'h0FFF;
  localparam logic [15:0] RST_CFG1    = 16'h08A3;
  localparam logic [15:0] RST_CFG2    = 16'h0100;
  localparam logic [15:0] RST_IEN     = 16'h0000;

  localparam logic [1:0] SRC_PWM = 2'h0;
  localparam logic [1:0] SRC_REG = 2'h2;

  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h2A;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  localparam logic [3:0] LAST_TX_BIT     = 4'h7;
  localparam logic [1:0] IDX_ADDR        = 2'h0;
  localparam logic [1:0] IDX_OFFSET      = 2'h1;
  localparam logic [1:0] IDX_HIGH        = 2'h2;
  localparam logic [1:0] IDX_LOW         = 2'h3;

  // Slope duration in ms per code, code 0 means disabled
  localparam logic [7:0][9:0] SLOPE_MS_TABLE = {10'h1F4, 10'h12C, 10'h0C8, 10'h064,
                                                10'h032, 10'h002, 10'h001, 10'h000};
  // Spread range in tenths of a percent per code
  localparam logic [3:0][6:0] SPREAD_TENTHS_TABLE = {7'h48, 7'h35, 7'h2B, 7'h21};

  typedef struct packed {
    logic       rsvd15;
    logic       pseudo_spread_en;
    logic [1:0] spread_modulation_rate;
    logic [1:0] spread_range;
    logic [1:0] brightness_source;
    logic [2:0] slope_sel;
    logic [2:0] dither_sel;
    logic       smooth_slope_on;
    logic       rsvd0;
  } lrb_cfg1_s;

  typedef struct packed {
    logic [3:0] mode_sel_detected;
    logic [3:0] string_phase_detected;
    logic [3:0] boost_freq_detected;
    logic [3:0] pwm_freq_detected;
  } lrb_pin_detect_s;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_RX    = 6'b000010,
    ST_ACK   = 6'b000100,
    ST_TX    = 6'b001000,
    ST_TXACK = 6'b010000,
    ST_SKIP  = 6'b100000
  } lrb_state_e;

  typedef struct packed {
    logic       scl_s1;
    logic       scl_s2;
    logic       scl_d;
    logic       sda_s1;
    logic       sda_s2;
    logic       sda_d;
    logic       sel_s1;
    logic       sel_s2;
    lrb_state_e st;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [1:0] idx;
    logic       rw;
    logic [7:0] offset;
    logic [7:0] hi;
    logic [7:0] tx;
    logic [15:0] rd_word;
    logic       drive_low;
    logic [15:0] bright;
    logic [15:0] current;
    lrb_cfg1_s  cfg1;
    logic [15:0] cfg2;
    logic [15:0] ien_sup;
    logic [15:0] ien_bst;
    logic [15:0] ien_led;
    logic [15:0] act_bright;
    logic [9:0] slope_ms;
    logic [6:0] spread_tenths;
  } lrb_regs_s;

  // Pins idle high so the synchronisers see no false start after reset
  localparam lrb_regs_s RST_STATE = '{scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
                                      sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
                                      st: ST_IDLE, bright: RST_BRIGHT,
                                      current: RST_CURRENT, cfg1: RST_CFG1,
                                      cfg2: RST_CFG2, ien_sup: RST_IEN,
                                      ien_bst: RST_IEN, ien_led: RST_IEN,
                                      default: '0};

endpackage
`default_nettype wire

/* File: src/lrb_register_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module lrb_register_bank (
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     scl_i,
  input  wire logic                     sda_i,
  output logic                          sda_o,
  output logic                          sda_oe_n_o,
  input  wire logic                     addr_sel_i,
  input  wire logic [15:0]              supply_fault_i,
  input  wire logic [15:0]              boost_fault_i,
  input  wire logic [15:0]              led_fault_i,
  input  wire logic [15:0]              fsm_state_i,
  input  wire logic [15:0]              pwm_input_duty_i,
  input  wire logic [15:0]              applied_duty_i,
  input  wire logic [11:0]              applied_current_dac_i,
  input  wire logic [9:0]               boost_target_code_i,
  input  wire lrb_pkg::lrb_pin_detect_s pin_detect_i,
  output logic [15:0]                   brightness_value_o,
  output logic [11:0]                   global_current_code_o,
  output lrb_pkg::lrb_cfg1_s            cfg1_o,
  output logic [15:0]                   cfg2_o,
  output logic [15:0]                   supply_irq_en_o,
  output logic [15:0]                   boost_irq_en_o,
  output logic [15:0]                   led_irq_en_o,
  output logic [15:0]                   active_brightness_o,
  output logic [9:0]                    slope_ms_o,
  output logic [6:0]                    spread_tenths_o
);

  lrb_pkg::lrb_regs_s r;
  lrb_pkg::lrb_regs_s n;
  logic               rise;
  logic               fall;
  logic               start;
  logic               stop;
  logic               wr_en;
  logic [15:0]        wr_data;
  logic               rd_load;
  logic [15:0]        rd_val;

  function automatic logic is_mapped(input logic [7:0] off);
    is_mapped = (off[0] == 1'b0) && (off <= lrb_pkg::OFF_LAST);
  endfunction

  always_comb
  begin
    n       = r;
    wr_en   = 1'b0;
    wr_data = {r.hi, r.shreg};
    rd_load = 1'b0;
    n.scl_s1 = scl_i;
    n.scl_s2 = r.scl_s1;
    n.scl_d  = r.scl_s2;
    n.sda_s1 = sda_i;
    n.sda_s2 = r.sda_s1;
    n.sda_d  = r.sda_s2;
    n.sel_s1 = addr_sel_i;
    n.sel_s2 = r.sel_s1;
    rise  = r.scl_s2 & ~r.scl_d;
    fall  = ~r.scl_s2 & r.scl_d;
    start = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
    stop  = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;
    // Diagnostics are sampled live at the address acknowledge, nothing is cleared
    rd_val = 16'h0000;
    if (is_mapped(r.offset))
    begin
      unique case (r.offset)
        lrb_pkg::OFF_BRIGHT:      rd_val = r.bright;
        lrb_pkg::OFF_CURRENT:     rd_val = r.current;
        lrb_pkg::OFF_CFG1:        rd_val = r.cfg1;
        lrb_pkg::OFF_CFG2:        rd_val = r.cfg2;
        lrb_pkg::OFF_IEN_SUP:     rd_val = r.ien_sup;
        lrb_pkg::OFF_IEN_BST:     rd_val = r.ien_bst;
        lrb_pkg::OFF_IEN_LED:     rd_val = r.ien_led;
        lrb_pkg::OFF_FLT_SUP:     rd_val = supply_fault_i;
        lrb_pkg::OFF_FLT_BST:     rd_val = boost_fault_i;
        lrb_pkg::OFF_FLT_LED:     rd_val = led_fault_i;
        lrb_pkg::OFF_DIAG_FSM:    rd_val = fsm_state_i;
        lrb_pkg::OFF_DIAG_PWMIN:  rd_val = pwm_input_duty_i;
        lrb_pkg::OFF_DIAG_PWMOUT: rd_val = applied_duty_i;
        lrb_pkg::OFF_DIAG_DAC:    rd_val = {4'h0, applied_current_dac_i};
        lrb_pkg::OFF_DIAG_BOOST:  rd_val = {6'h00, boost_target_code_i};
        lrb_pkg::OFF_DIAG_PIN:    rd_val = pin_detect_i;
        default:                  rd_val = 16'h0000;
      endcase
    end
    if (start)
    begin
      n.st        = lrb_pkg::ST_RX;
      n.cnt       = 4'h0;
      n.idx       = lrb_pkg::IDX_ADDR;
      n.drive_low = 1'b0;
    end
    else if (stop)
    begin
      n.st        = lrb_pkg::ST_IDLE;
      n.drive_low = 1'b0;
    end
    else
    begin
      unique case (r.st)
        lrb_pkg::ST_IDLE, lrb_pkg::ST_SKIP:
        begin
          n.drive_low = 1'b0;
        end
        lrb_pkg::ST_RX:
        begin
          if (rise && (r.cnt < lrb_pkg::BITS_PER_BYTE))
          begin
            n.shreg = {r.shreg[6:0], r.sda_s2};
            n.cnt   = r.cnt + 4'h1;
          end
          else if (fall && (r.cnt == lrb_pkg::BITS_PER_BYTE))
          begin
            n.st        = lrb_pkg::ST_ACK;
            n.drive_low = 1'b1;
            unique case (r.idx)
              lrb_pkg::IDX_ADDR:
              begin
                if (r.shreg[7:1] == {lrb_pkg::SLAVE_ADDR_BASE[6:1], r.sel_s2})
                begin
                  n.rw = r.shreg[0];
                  if (r.shreg[0])
                  begin
                    rd_load   = 1'b1;
                    n.rd_word = rd_val;
                    n.idx     = lrb_pkg::IDX_HIGH;
                  end
                end
                else
                begin
                  n.st        = lrb_pkg::ST_SKIP;
                  n.drive_low = 1'b0;
                end
              end
              lrb_pkg::IDX_OFFSET: n.offset = r.shreg;
              lrb_pkg::IDX_HIGH:   n.hi = r.shreg;
              lrb_pkg::IDX_LOW:    wr_en = 1'b1;
            endcase
          end
        end
        lrb_pkg::ST_ACK:
        begin
          if (fall)
          begin
            n.cnt = 4'h0;
            if (r.rw)
            begin
              n.st        = lrb_pkg::ST_TX;
              n.tx        = r.rd_word[15:8];
              n.drive_low = ~r.rd_word[15];
            end
            else if (r.idx == lrb_pkg::IDX_LOW)
            begin
              // Bytes past the fourth are not acknowledged
              n.st        = lrb_pkg::ST_SKIP;
              n.drive_low = 1'b0;
            end
            else
            begin
              n.st        = lrb_pkg::ST_RX;
              n.idx       = r.idx + 2'h1;
              n.drive_low = 1'b0;
            end
          end
        end
        lrb_pkg::ST_TX:
        begin
          if (fall)
          begin
            if (r.cnt == lrb_pkg::LAST_TX_BIT)
            begin
              n.st        = lrb_pkg::ST_TXACK;
              n.cnt       = 4'h0;
              n.drive_low = 1'b0;
            end
            else
            begin
              n.tx        = {r.tx[6:0], 1'b0};
              n.cnt       = r.cnt + 4'h1;
              n.drive_low = ~r.tx[6];
            end
          end
        end
        lrb_pkg::ST_TXACK:
        begin
          if (rise)
          begin
            if (r.sda_s2)
            begin
              n.st = lrb_pkg::ST_SKIP;
            end
            else
            begin
              n.cnt = 4'h1;
            end
          end
          else if (fall && (r.cnt == 4'h1))
          begin
            n.cnt = 4'h0;
            if (r.idx == lrb_pkg::IDX_HIGH)
            begin
              n.st        = lrb_pkg::ST_TX;
              n.idx       = lrb_pkg::IDX_LOW;
              n.tx        = r.rd_word[7:0];
              n.drive_low = ~r.rd_word[7];
            end
            else
            begin
              n.st = lrb_pkg::ST_SKIP;
            end
          end
        end
      endcase
    end
    // Status and diagnostic offsets fall to default and are never written
    if (wr_en && is_mapped(r.offset))
    begin
      unique case (r.offset)
        lrb_pkg::OFF_BRIGHT:  n.bright  = wr_data;
        lrb_pkg::OFF_CURRENT: n.current = wr_data;
        lrb_pkg::OFF_CFG1:    n.cfg1    = wr_data;
        lrb_pkg::OFF_CFG2:    n.cfg2    = wr_data;
        lrb_pkg::OFF_IEN_SUP: n.ien_sup = wr_data;
        lrb_pkg::OFF_IEN_BST: n.ien_bst = wr_data;
        lrb_pkg::OFF_IEN_LED: n.ien_led = wr_data;
        default:              n.ien_led = r.ien_led;
      endcase
    end
    // Reserved source codes fall back to the PWM input
    if (r.cfg1.brightness_source == lrb_pkg::SRC_REG)
    begin
      n.act_bright = r.bright;
    end
    else
    begin
      n.act_bright = pwm_input_duty_i;
    end
    n.slope_ms      = lrb_pkg::SLOPE_MS_TABLE[r.cfg1.slope_sel];
    n.spread_tenths = lrb_pkg::SPREAD_TENTHS_TABLE[r.cfg1.spread_range];
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r <= lrb_pkg::RST_STATE;
    end
    else
    begin
      r <= n;
    end
  end

  assign sda_o                 = 1'b0;
  assign sda_oe_n_o            = ~r.drive_low;
  assign brightness_value_o    = r.bright;
  assign global_current_code_o = r.current[11:0];
  assign cfg1_o                = r.cfg1;
  assign cfg2_o                = r.cfg2;
  assign supply_irq_en_o       = r.ien_sup;
  assign boost_irq_en_o        = r.ien_bst;
  assign led_irq_en_o          = r.ien_led;
  assign active_brightness_o   = r.act_bright;
  assign slope_ms_o            = r.slope_ms;
  assign spread_tenths_o       = r.spread_tenths;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_addr_byte_done;
    (r.st == lrb_pkg::ST_RX) && fall && (r.cnt == lrb_pkg::BITS_PER_BYTE)
      && (r.idx == lrb_pkg::IDX_ADDR)
      && (r.shreg[7:1] == {lrb_pkg::SLAVE_ADDR_BASE[6:1], r.sel_s2});
  endsequence

  sequence s_ack_driven;
    (r.st == lrb_pkg::ST_ACK) && !sda_oe_n_o;
  endsequence

  a_addr_ack_drive: assert property (s_addr_byte_done |=> s_ack_driven)
    else $error("Matching address byte not acknowledged");

  a_brt_write_take: assert property (
    wr_en && (r.offset == lrb_pkg::OFF_BRIGHT) |=> brightness_value_o == $past(wr_data))
    else $error("Brightness write not taken");

  a_cur_write_take: assert property (
    wr_en && (r.offset == lrb_pkg::OFF_CURRENT)
      |=> (r.current == $past(wr_data)) && (global_current_code_o == $past(wr_data[11:0])))
    else $error("Current write not taken in full");

  a_cfg_write_take: assert property (
    wr_en && (r.offset == lrb_pkg::OFF_CFG1) |=> cfg1_o == $past(wr_data))
    else $error("Config one write not taken");

  a_diag_write_drop: assert property (
    wr_en && (r.offset >= lrb_pkg::OFF_FLT_SUP)
      |=> $stable(r.bright) && $stable(r.current) && $stable(r.cfg1) && $stable(r.cfg2))
    else $error("Write to status or diagnostic offset changed a register");

  a_src_reg_sel: assert property (
    (r.cfg1.brightness_source == lrb_pkg::SRC_REG) && $stable(r.cfg1) && $stable(r.bright)
      |=> active_brightness_o == $past(r.bright))
    else $error("Register brightness source not applied");

  a_src_pwm_sel: assert property (
    (r.cfg1.brightness_source == lrb_pkg::SRC_PWM) |=> active_brightness_o == $past(pwm_input_duty_i))
    else $error("PWM brightness source not applied");

  a_slope_max_code: assert property (
    (r.cfg1.slope_sel == 3'h7) |=> slope_ms_o == 10'h1F4)
    else $error("Slope code 7 not 500 ms");

  a_spread_top_code: assert property (
    (r.cfg1.spread_range == 2'h3) |=> spread_tenths_o == 7'h48)
    else $error("Spread code 3 not 7.2 percent");

  a_duty_read_live: assert property (
    rd_load && (r.offset == lrb_pkg::OFF_DIAG_PWMOUT) |=> r.rd_word == $past(applied_duty_i))
    else $error("PWM output diagnostic not live");

endmodule // lrb_register_bank
`default_nettype wire

/* File: sim/lrb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lrb_host_model #(
  parameter int HALF = 5
) (
  input  wire logic sys_clk_i,
  input  wire logic sda_i,
  output var logic  scl_o,
  output var logic  sda_o
);
  // Released SDA reads high through the bench pull-up
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick;
    repeat (HALF) @(posedge sys_clk_i);
    #1;
  endtask
  // SDA moves a phase after SCL falls, so no false START or STOP
  task automatic put_bit(input logic b);
    tick();
    sda_o = b;
    tick();
    scl_o = 1'b1;
    tick();
    scl_o = 1'b0;
  endtask
  task automatic get_bit(output logic b);
    tick();
    sda_o = 1'b1;
    tick();
    scl_o = 1'b1;
    tick();
    b = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic start;
    tick();
    sda_o = 1'b1;
    tick();
    scl_o = 1'b1;
    tick();
    sda_o = 1'b0;
    tick();
    scl_o = 1'b0;
  endtask
  task automatic stop;
    tick();
    sda_o = 1'b0;
    tick();
    scl_o = 1'b1;
    tick();
    sda_o = 1'b1;
    tick();
  endtask
  task automatic put_byte(input logic [7:0] d, inout logic nack);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(a);
    nack = nack | a;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(last);
  endtask
  // Always the whole frame, high data byte first
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] off,
                           input logic [15:0] v, output logic nack);
    nack = 1'b0;
    start();
    put_byte({dev, 1'b0}, nack);
    put_byte(off, nack);
    put_byte(v[15:8], nack);
    put_byte(v[7:0], nack);
    stop();
  endtask
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] off,
                          output logic [15:0] v, output logic nack);
    nack = 1'b0;
    start();
    put_byte({dev, 1'b0}, nack);
    put_byte(off, nack);
    start();
    put_byte({dev, 1'b1}, nack);
    get_byte(1'b0, v[15:8]);
    get_byte(1'b1, v[7:0]);
    stop();
  endtask
endmodule // lrb_host_model
`default_nettype wire

/* File: sim/lrb_register_bank_test.sv */
`timescale 1ns/1ps
`default_nettype none
module lrb_register_bank_test;
  localparam int LIMIT = 80000;
  logic                     sys_clk_i = 1'b0;
  logic                     rst_i = 1'b1;
  logic                     scl, sda_host, sda_wire, sda_o, sda_oe_n_o;
  logic                     addr_sel_i = 1'b0;
  logic [15:0]              sup_f = '0, bst_f = '0, led_f = '0, fsm = '0, pwm_in = '0;
  logic [15:0]              duty = '0, brt_o, cfg2_o, sup_en, bst_en, led_en, act_brt;
  logic [11:0]              dac = '0, cur_o;
  logic [9:0]               bcode = '0, slope_o;
  logic [6:0]               spread_o;
  logic [6:0]               dev_addr = 7'h2A;
  lrb_pkg::lrb_pin_detect_s pin_det = '0;
  lrb_pkg::lrb_cfg1_s       cfg1_o;
  int                       num_errors = 0, num_checks = 0, cycles = 0;
  logic [15:0]              exp_reg [7] = '{16'h0000, 16'h0FFF, 16'h08A3, 16'h0100,
                                            16'h0000, 16'h0000, 16'h0000};
  logic [15:0]              slope_tab [8] = '{16'h0000, 16'h0001, 16'h0002, 16'h0032,
                                              16'h0064, 16'h00C8, 16'h012C, 16'h01F4};
  logic [15:0]              spread_tab [4] = '{16'h0021, 16'h002B, 16'h0035, 16'h0048};

  assign sda_wire = sda_host & (sda_oe_n_o | sda_o);
  initial
  begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  lrb_register_bank lrb_register_bank_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_wire),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .addr_sel_i(addr_sel_i),
    .supply_fault_i(sup_f), .boost_fault_i(bst_f), .led_fault_i(led_f),
    .fsm_state_i(fsm), .pwm_input_duty_i(pwm_in), .applied_duty_i(duty),
    .applied_current_dac_i(dac), .boost_target_code_i(bcode), .pin_detect_i(pin_det),
    .brightness_value_o(brt_o), .global_current_code_o(cur_o), .cfg1_o(cfg1_o),
    .cfg2_o(cfg2_o), .supply_irq_en_o(sup_en), .boost_irq_en_o(bst_en),
    .led_irq_en_o(led_en), .active_brightness_o(act_brt), .slope_ms_o(slope_o),
    .spread_tenths_o(spread_o));
  lrb_host_model lrb_host_model_inst (
    .sys_clk_i(sys_clk_i), .sda_i(sda_wire), .scl_o(scl), .sda_o(sda_host));

  task automatic end_sim;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge sys_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      num_errors = num_errors + 1;
      end_sim();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      num_errors = num_errors + 1;
    end
  endtask
  // Reads of holes come back zero; diagnostics are the live inputs
  function automatic logic [15:0] model_rd(input logic [7:0] off);
    if (off[0] || off > 8'h1E)
      return 16'h0000;
    case (off)
      8'h0E: return sup_f;
      8'h10: return bst_f;
      8'h12: return led_f;
      8'h14: return fsm;
      8'h16: return pwm_in;
      8'h18: return duty;
      8'h1A: return {4'h0, dac};
      8'h1C: return {6'h00, bcode};
      8'h1E: return pin_det;
      default: return exp_reg[off[3:1]];
    endcase
  endfunction
  task automatic wr(input logic [7:0] off, input logic [15:0] v, input logic exp_nk);
    logic nk;
    lrb_host_model_inst.write_reg(dev_addr, off, v, nk);
    check({15'h0000, nk}, {15'h0000, exp_nk});
    if (!exp_nk && off <= 8'h0C)
      exp_reg[off[3:1]] = v;
  endtask
  task automatic rd_chk(input logic [7:0] off);
    logic [15:0] v;
    logic        nk;
    lrb_host_model_inst.read_reg(dev_addr, off, v, nk);
    check({15'h0000, nk}, 16'h0000);
    check(v, model_rd(off));
  endtask
  task automatic rand_live;
    @(posedge sys_clk_i);
    #1;
    sup_f = 16'($urandom);
    bst_f = 16'($urandom);
    led_f = 16'($urandom);
    fsm = 16'($urandom);
    pwm_in = 16'($urandom);
    duty = 16'($urandom);
    dac = 12'($urandom);
    bcode = 10'($urandom);
    pin_det = lrb_pkg::lrb_pin_detect_s'(16'($urandom));
  endtask

  initial
  begin
    logic [15:0] v;
    void'($urandom(50540));
    repeat (6) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    rand_live();
    repeat (6) @(posedge sys_clk_i);
    for (int i = 0; i < 7; i++) rd_chk(8'(2 * i));
    check({6'h00, slope_o}, slope_tab[5]);
    check({9'h000, spread_o}, spread_tab[2]);
    check(act_brt, pwm_in);
    $display("test reset_values done");
    for (int i = 0; i < 7; i++) wr(8'(2 * i), 16'($urandom), 1'b0);
    for (int i = 0; i < 7; i++) rd_chk(8'(2 * i));
    check(brt_o, exp_reg[0]);
    check({4'h0, cur_o}, exp_reg[1] & 16'h0FFF);
    check(cfg1_o, exp_reg[2]);
    check(cfg2_o, exp_reg[3]);
    check(sup_en, exp_reg[4]);
    check(bst_en, exp_reg[5]);
    check(led_en, exp_reg[6]);
    $display("test read_write done");
    rand_live();
    for (int i = 7; i < 16; i++) rd_chk(8'(2 * i));
    rd_chk(8'h05);
    rd_chk(8'h21);
    wr(8'h18, 16'($urandom), 1'b0);
    rd_chk(8'h18);
    rand_live();
    rd_chk(8'h18);
    rd_chk(8'h1A);
    $display("test diagnostics done");
    // Slope and spread codes walked together; source codes wrap through 0..3
    for (int i = 0; i < 8; i++)
    begin
      v = {1'b0, 3'($urandom), 2'(i), 2'(i), 3'(i), 5'($urandom)};
      wr(8'h04, v, 1'b0);
      check(cfg1_o, v);
      check({6'h00, slope_o}, slope_tab[i]);
      check({9'h000, spread_o}, spread_tab[i % 4]);
      check(act_brt, (i % 4 == 2) ? exp_reg[0] : pwm_in);
    end
    $display("test config_decode done");
    @(posedge sys_clk_i);
    #1;
    addr_sel_i = 1'b1;
    repeat (6) @(posedge sys_clk_i);
    wr(8'h00, 16'($urandom), 1'b1);
    dev_addr = 7'h2B;
    rd_chk(8'h00);
    check(brt_o, exp_reg[0]);
    $display("test address_select done");
    // A second reset in mid-run must bring every register back to its reset value
    @(posedge sys_clk_i);
    #1;
    rst_i = 1'b1;
    repeat (6) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    repeat (6) @(posedge sys_clk_i);
    exp_reg = '{16'h0000, 16'h0FFF, 16'h08A3, 16'h0100, 16'h0000, 16'h0000, 16'h0000};
    check(brt_o, 16'h0000);
    check({4'h0, cur_o}, 16'h0FFF);
    check(cfg1_o, 16'h08A3);
    check({6'h00, slope_o}, slope_tab[5]);
    check({9'h000, spread_o}, spread_tab[2]);
    check(act_brt, pwm_in);
    for (int i = 0; i < 7; i++) rd_chk(8'(2 * i));
    $display("test mid_reset done");
    end_sim();
  end
endmodule // lrb_register_bank_test
`default_nettype wire
